// *** prb_pkg.sv ***
// Package of constants and types for the port register bank
//------------------------------------------------------------------------------
// Function
// - Pin-value writes land in the output latch
// - Pin-value reads return synchronised pin levels
// - Fifth port bit 3 reads pin only without master clear
// - Fifth port pin-value bits 7-4 read zero
// - Analog select set disables digital input buffer
// - First port analog select: bits 5,3-0 only
// - Second port analog select: bits 5-0 only
// - Third port analog select: bits 7-2 only
// - Fourth port analog select: all eight bits
// - Fifth port analog select: bits 2-0 only
// - Direction one tri-states pin, zero drives latch
// - Fifth direction bit 7 is input pull-up enable
// - Fifth direction bits 2-0 steer three pins
// - Latches hold values, kept over non-power resets
// - Power and brown-out resets differ from others
// - Fifth port latch: bits 2-0 only
// - Second port pull-ups enable per bit, reset one
// - Fourth port and fifth I/O need large variant
// - Analog pins read zero, output path unaffected
// - Analog select and direction reset to one
//------------------------------------------------------------------------------
package prb_pkg;

   //---------------------------------------------------------------------------
   // Geometry and types
   //---------------------------------------------------------------------------
   localparam int PRB_NPORT  = 5;
   localparam int PRB_PORT_D = 3;
   localparam int PRB_PORT_E = 4;
   localparam int PRB_ADDR_W = 5;
   localparam int PRB_PIN_W  = PRB_NPORT * 8;

   typedef logic [7:0]                prb_byte_t;
   typedef prb_byte_t [PRB_NPORT-1:0] prb_bank_t;

   //---------------------------------------------------------------------------
   // Register offsets, one register per port from each base
   //---------------------------------------------------------------------------
   localparam logic [PRB_ADDR_W-1:0] PRB_OFF_PIN_BASE   = 5'h00;
   localparam logic [PRB_ADDR_W-1:0] PRB_OFF_LAT_BASE   = 5'h05;
   localparam logic [PRB_ADDR_W-1:0] PRB_OFF_DIR_BASE   = 5'h0A;
   localparam logic [PRB_ADDR_W-1:0] PRB_OFF_ANSEL_BASE = 5'h0F;
   localparam logic [PRB_ADDR_W-1:0] PRB_OFF_PULLUP_B   = 5'h14;

   //---------------------------------------------------------------------------
   // Implemented-bit masks, index 0 is the first port
   //---------------------------------------------------------------------------
   localparam prb_bank_t PRB_ANSEL_MASK  = {8'h07, 8'hFF, 8'hFC, 8'h3F, 8'h2F};
   localparam prb_bank_t PRB_IO_MASK     = {8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   localparam prb_bank_t PRB_SMALL_AVAIL = {8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};
   localparam prb_bank_t PRB_ALL_AVAIL   = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   localparam int        PRB_E_INPUT_BIT  = 3;
   localparam int        PRB_E_PULLUP_BIT = 7;

   //---------------------------------------------------------------------------
   // Reset values
   //---------------------------------------------------------------------------
   localparam prb_byte_t PRB_ANSEL_RST    = 8'hFF;
   localparam prb_byte_t PRB_DIR_RST      = 8'hFF;
   localparam prb_byte_t PRB_PULLUP_RST   = 8'hFF;
   localparam prb_byte_t PRB_LAT_POR_RST  = 8'h00;
   localparam logic      PRB_PULLUP_E_RST = 1'b1;
   localparam prb_byte_t PRB_ZERO         = 8'h00;

endpackage : prb_pkg

// *** prb_pad_if.sv ***
// Interface between the register core and the pad logic
`timescale 1ns/1ps
interface prb_pad_if;
   import prb_pkg::*;
   prb_bank_t latch;
   prb_bank_t dir;
   prb_bank_t ansel;
   prb_bank_t din_sync;
   prb_bank_t din_read;
   prb_bank_t dout;
   prb_bank_t oe_n;

   modport core (output latch, output dir, output ansel, output din_sync,
                 input  din_read, input dout, input oe_n);
   modport pad  (input  latch, input dir, input ansel, input din_sync,
                 output din_read, output dout, output oe_n);
endinterface : prb_pad_if

// *** prb_sync.sv ***
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module prb_sync #(
   parameter int W = 40
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   // Data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         logic meta_ff;
         logic sync_ff;
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
            end else begin
               meta_ff <= async_i[gi];
               sync_ff <= meta_ff;
            end
         end
         assign sync_o[gi] = sync_ff;
      end
   endgenerate
endmodule : prb_sync

// *** prb_pad.sv ***
// Pad logic: input buffer gating and output driver control per port
`timescale 1ns/1ps
module prb_pad
   import prb_pkg::*;
(
   prb_pad_if.pad pad_if
);
   genvar gp;
   generate
      for (gp = 0; gp < PRB_NPORT; gp++) begin : g_port
         // Disabled input buffer reads as zero
         assign pad_if.din_read[gp] = pad_if.din_sync[gp] & ~pad_if.ansel[gp];
         // Output path ignores analog select
         assign pad_if.dout[gp]     = pad_if.latch[gp];
         assign pad_if.oe_n[gp]     = pad_if.dir[gp];
      end
   endgenerate
endmodule : prb_pad

// *** prb_port_bank.sv ***
// Top of the port register bank: registers, bus slave and pin control
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
module prb_port_bank
   import prb_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // Clock and resets
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   input  wire logic                  soft_reset_i,
   // Register bus
   input  wire logic [PRB_ADDR_W-1:0] reg_addr_i,
   input  wire logic [7:0]            reg_wdata_i,
   input  wire logic                  reg_we_i,
   input  wire logic                  reg_re_i,
   output logic      [7:0]            reg_rdata_o,
   // Configuration
   input  wire logic                  master_clear_pin_enable_i,
   // Pins
   input  wire prb_bank_t             pad_in_i,
   output prb_bank_t                  pad_out_o,
   output prb_bank_t                  pad_oe_n_o,
   // Pull-ups
   output logic      [7:0]            second_port_pullup_enable_o,
   output logic                       input_pin_pullup_enable_o
);

   //---------------------------------------------------------------------------
   // Storage
   //---------------------------------------------------------------------------
   prb_bank_t              output_latch_reg_ff;
   prb_bank_t              direction_reg_ff;
   prb_bank_t              analog_select_ff;
   prb_byte_t              second_port_pullup_ff;
   logic                   input_pin_pullup_ff;
   prb_byte_t              rdata_ff;
   prb_byte_t              nxt_rdata;

   //---------------------------------------------------------------------------
   // Variant masks
   //---------------------------------------------------------------------------
   prb_bank_t              avail;
   prb_bank_t              io_mask;
   prb_bank_t              ansel_mask;
   logic [PRB_NPORT-1:0]   hit_pin;
   logic [PRB_NPORT-1:0]   hit_lat;
   logic [PRB_NPORT-1:0]   hit_dir;
   logic [PRB_NPORT-1:0]   hit_ansel;
   logic                   hit_pullup_b;
   logic [PRB_PIN_W-1:0]   pin_sync_flat;
   prb_pad_if              pad_if ();

   // Small variant drops the fourth port and the fifth port I/O bits
   assign avail = LARGE_VARIANT ? PRB_ALL_AVAIL : PRB_SMALL_AVAIL;

   genvar gp;
   generate
      for (gp = 0; gp < PRB_NPORT; gp++) begin : g_mask
         assign io_mask[gp]    = PRB_IO_MASK[gp] & avail[gp];
         assign ansel_mask[gp] = PRB_ANSEL_MASK[gp] & avail[gp];
      end
   endgenerate

   //---------------------------------------------------------------------------
   // Address decode
   //---------------------------------------------------------------------------
   generate
      for (gp = 0; gp < PRB_NPORT; gp++) begin : g_dec
         localparam logic [PRB_ADDR_W-1:0] IDX = PRB_ADDR_W'(gp);
         assign hit_pin[gp]   = (reg_addr_i == PRB_OFF_PIN_BASE + IDX);
         assign hit_lat[gp]   = (reg_addr_i == PRB_OFF_LAT_BASE + IDX);
         assign hit_dir[gp]   = (reg_addr_i == PRB_OFF_DIR_BASE + IDX);
         assign hit_ansel[gp] = (reg_addr_i == PRB_OFF_ANSEL_BASE + IDX);
      end
   endgenerate
   assign hit_pullup_b = (reg_addr_i == PRB_OFF_PULLUP_B);

   //---------------------------------------------------------------------------
   // Output latches
   //---------------------------------------------------------------------------
   // Only power-on or brown-out clears them; soft reset leaves them alone
   // so latched levels survive a warm restart, while soft reset tri-states the pins.
   generate
      for (gp = 0; gp < PRB_NPORT; gp++) begin : g_lat
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               output_latch_reg_ff[gp] <= PRB_LAT_POR_RST;
            end else if (reg_we_i && (hit_pin[gp] || hit_lat[gp])) begin
               // Pin-value and latch addresses share one store
               output_latch_reg_ff[gp] <= reg_wdata_i & io_mask[gp];
            end
         end
      end
   endgenerate

   //---------------------------------------------------------------------------
   // Direction registers
   //---------------------------------------------------------------------------
   generate
      for (gp = 0; gp < PRB_NPORT; gp++) begin : g_dir
         // Reset value folds in the variant, so absent ports read zero apart from the fifth port's pull-up bit 7
         localparam prb_byte_t DIR_POR = PRB_DIR_RST & PRB_IO_MASK[gp] &
            (LARGE_VARIANT ? PRB_ALL_AVAIL[gp] : PRB_SMALL_AVAIL[gp]);
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               direction_reg_ff[gp] <= DIR_POR;
            end else if (soft_reset_i) begin
               direction_reg_ff[gp] <= PRB_DIR_RST & io_mask[gp];
            end else if (reg_we_i && hit_dir[gp]) begin
               direction_reg_ff[gp] <= reg_wdata_i & io_mask[gp];
            end
         end
      end
   endgenerate

   //---------------------------------------------------------------------------
   // Analog select registers
   //---------------------------------------------------------------------------
   generate
      for (gp = 0; gp < PRB_NPORT; gp++) begin : g_ansel
         localparam prb_byte_t ANSEL_POR = PRB_ANSEL_RST & PRB_ANSEL_MASK[gp] &
            (LARGE_VARIANT ? PRB_ALL_AVAIL[gp] : PRB_SMALL_AVAIL[gp]);
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               analog_select_ff[gp] <= ANSEL_POR;
            end else if (soft_reset_i) begin
               analog_select_ff[gp] <= PRB_ANSEL_RST & ansel_mask[gp];
            end else if (reg_we_i && hit_ansel[gp]) begin
               analog_select_ff[gp] <= reg_wdata_i & ansel_mask[gp];
            end
         end
      end
   endgenerate

   //---------------------------------------------------------------------------
   // Pull-up enables
   //---------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         second_port_pullup_ff <= PRB_PULLUP_RST;
      end else if (soft_reset_i) begin
         second_port_pullup_ff <= PRB_PULLUP_RST;
      end else if (reg_we_i && hit_pullup_b) begin
         second_port_pullup_ff <= reg_wdata_i;
      end
   end

   // Pull-up bit lives in the fifth direction register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         input_pin_pullup_ff <= PRB_PULLUP_E_RST;
      end else if (soft_reset_i) begin
         input_pin_pullup_ff <= PRB_PULLUP_E_RST;
      end else if (reg_we_i && hit_dir[PRB_PORT_E]) begin
         input_pin_pullup_ff <= reg_wdata_i[PRB_E_PULLUP_BIT];
      end
   end

   //---------------------------------------------------------------------------
   // Pin input path
   //---------------------------------------------------------------------------
   prb_sync #(
      .W        (PRB_PIN_W)
   ) u_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  (pad_in_i),
      .sync_o   (pin_sync_flat)
   );

   assign pad_if.din_sync = pin_sync_flat;
   assign pad_if.ansel    = analog_select_ff;
   assign pad_if.latch    = output_latch_reg_ff;
   // Absent or unimplemented bits never drive their pad
   generate
      for (gp = 0; gp < PRB_NPORT; gp++) begin : g_oe
         assign pad_if.dir[gp] = direction_reg_ff[gp] | ~io_mask[gp];
      end
   endgenerate

   prb_pad u_pad (
      .pad_if   (pad_if)
   );

   //---------------------------------------------------------------------------
   // Read multiplexer
   //---------------------------------------------------------------------------
   // A read of the pin value sees the wire, not the latch, so a
   // read-modify-write on an analog or loaded pin may flip latch bits.
   always_comb begin
      nxt_rdata = PRB_ZERO;
      if (reg_re_i) begin
         for (int p = 0; p < PRB_NPORT; p++) begin
            if (hit_pin[p]) begin
               nxt_rdata = pad_if.din_read[p] & io_mask[p];
               if (p == PRB_PORT_E) begin
                  // Input-only bit, lost to the master clear function
                  nxt_rdata[PRB_E_INPUT_BIT] = ~master_clear_pin_enable_i &
                     pad_if.din_sync[PRB_PORT_E][PRB_E_INPUT_BIT];
               end
            end
            if (hit_lat[p]) begin
               nxt_rdata = output_latch_reg_ff[p];
            end
            if (hit_dir[p]) begin
               nxt_rdata = direction_reg_ff[p];
               if (p == PRB_PORT_E) begin
                  nxt_rdata[PRB_E_PULLUP_BIT] = input_pin_pullup_ff;
               end
            end
            if (hit_ansel[p]) begin
               nxt_rdata = analog_select_ff[p];
            end
         end
         if (hit_pullup_b) begin
            nxt_rdata = second_port_pullup_ff;
         end
      end
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_ff <= PRB_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   //---------------------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------------------
   assign reg_rdata_o                 = rdata_ff;
   assign pad_out_o                   = pad_if.dout;
   assign pad_oe_n_o                  = pad_if.oe_n;
   assign second_port_pullup_enable_o = second_port_pullup_ff;
   assign input_pin_pullup_enable_o   = input_pin_pullup_ff;

endmodule : prb_port_bank

// *** prb_port_bank_checker.sv ***
// Concurrent checks on the port register bank top-level ports
`timescale 1ns/1ps
module prb_port_bank_checker
   import prb_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   input  wire logic                  soft_reset_i,
   input  wire logic [PRB_ADDR_W-1:0] reg_addr_i,
   input  wire logic [7:0]            reg_wdata_i,
   input  wire logic                  reg_we_i,
   input  wire logic                  reg_re_i,
   input  wire logic [7:0]            reg_rdata_o,
   input  wire logic                  master_clear_pin_enable_i,
   input  wire prb_bank_t             pad_in_i,
   input  wire prb_bank_t             pad_out_o,
   input  wire prb_bank_t             pad_oe_n_o,
   input  wire logic [7:0]            second_port_pullup_enable_o,
   input  wire logic                  input_pin_pullup_enable_o
);
   //---------------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_wr(logic [PRB_ADDR_W-1:0] a);
      reg_we_i && (reg_addr_i == a);
   endsequence
   sequence s_rd(logic [PRB_ADDR_W-1:0] a);
      reg_re_i && (reg_addr_i == a);
   endsequence

   a_read_idle_zero: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
      else $error("read data not zero outside read cycle");
   a_pin_wr_latch: assert property (s_wr(5'h00) |=> pad_out_o[0] == $past(reg_wdata_i))
      else $error("pin write did not reach output latch");
   a_late_wr_mask: assert property (s_wr(5'h09)
      |=> pad_out_o[4] == ($past(reg_wdata_i) & (LARGE_VARIANT ? 8'h07 : 8'h00)))
      else $error("fifth port latch mask wrong");
   a_dir_drive: assert property (s_wr(5'h0A) && !soft_reset_i
      |=> pad_oe_n_o[0] == $past(reg_wdata_i))
      else $error("direction write not on output enable");
   a_soft_dir_ones: assert property (soft_reset_i |=> &pad_oe_n_o)
      else $error("direction not reset by soft reset");
   a_soft_pullups: assert property (soft_reset_i
      |=> second_port_pullup_enable_o == 8'hFF && input_pin_pullup_enable_o)
      else $error("pull-ups not reset by soft reset");
   a_latch_kept: assert property (soft_reset_i && !reg_we_i |=> $stable(pad_out_o))
      else $error("latch changed on soft reset");
   a_pullup_write: assert property (s_wr(5'h14) && !soft_reset_i
      |=> second_port_pullup_enable_o == $past(reg_wdata_i))
      else $error("pull-up write not on output");
   a_e_high_zero: assert property (s_rd(5'h04) |=> reg_rdata_o[7:4] == 4'h0)
      else $error("fifth port pin bits 7-4 not zero");
   a_ansel_a_mask: assert property (s_rd(5'h0F) |=> (reg_rdata_o & 8'hD0) == 8'h00)
      else $error("first analog select spare bits set");
endmodule : prb_port_bank_checker

bind prb_port_bank prb_port_bank_checker #(.LARGE_VARIANT(LARGE_VARIANT)) i_prb_port_bank_checker (
   .clk_i(clk_i), .resetn_i(resetn_i), .soft_reset_i(soft_reset_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
   .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
   .master_clear_pin_enable_i(master_clear_pin_enable_i), .pad_in_i(pad_in_i),
   .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
   .second_port_pullup_enable_o(second_port_pullup_enable_o),
   .input_pin_pullup_enable_o(input_pin_pullup_enable_o));

// *** prb_port_bank_tb.sv ***
// Self-checking testbench of the port register bank
`timescale 1ns/1ps
module prb_port_bank_tb
   import prb_pkg::*;
;
   //---------------------------------------------------------------------------
   // Signals
   //---------------------------------------------------------------------------
   logic                  clk_i        = 1'b0;
   logic                  resetn_i     = 1'b0;
   logic                  soft_reset_i = 1'b0;
   logic [PRB_ADDR_W-1:0] reg_addr_i   = 5'h00;
   logic [7:0]            reg_wdata_i  = 8'h00;
   logic                  reg_we_i     = 1'b0;
   logic                  reg_re_i     = 1'b0;
   logic                  mclr_en      = 1'b1;
   prb_bank_t             pad_in_i     = '0;
   logic [7:0]            reg_rdata_o;
   prb_bank_t             pad_out_o;
   prb_bank_t             pad_oe_n_o;
   logic [7:0]            pullup_b;
   logic                  pullup_e;
   logic [7:0]            rdata_s;
   prb_bank_t             pad_out_s;
   prb_bank_t             pad_oe_n_s;
   int                    miscompares  = 0;
   int                    comparisons  = 0;
   int                    cycles       = 0;
   prb_byte_t             ansel_rst [PRB_NPORT] = '{8'h2F, 8'h3F, 8'hFC, 8'hFF, 8'h07};

   prb_port_bank #(.LARGE_VARIANT(1'b1)) i_prb_port_bank (
      .clk_i(clk_i), .resetn_i(resetn_i), .soft_reset_i(soft_reset_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
      .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
      .master_clear_pin_enable_i(mclr_en), .pad_in_i(pad_in_i),
      .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
      .second_port_pullup_enable_o(pullup_b), .input_pin_pullup_enable_o(pullup_e));

   // Small variant on the same bus, to see that absent ports stay dead
   prb_port_bank #(.LARGE_VARIANT(1'b0)) i_prb_port_bank_small (
      .clk_i(clk_i), .resetn_i(resetn_i), .soft_reset_i(soft_reset_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
      .reg_re_i(reg_re_i), .reg_rdata_o(rdata_s),
      .master_clear_pin_enable_i(mclr_en), .pad_in_i(pad_in_i),
      .pad_out_o(pad_out_s), .pad_oe_n_o(pad_oe_n_s),
      .second_port_pullup_enable_o(), .input_pin_pullup_enable_o());

   always #5 clk_i = ~clk_i;

   //---------------------------------------------------------------------------
   // Tasks
   //---------------------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wr(input logic [PRB_ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_we_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_we_i    <= 1'b0;
      // Let the write edge settle before any output is looked at
      #1;
   endtask : wr

   // Data stand only in the cycle after the read edge
   task automatic rd(input logic [PRB_ADDR_W-1:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_i);
      reg_re_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_re_i   <= 1'b0;
      #1;
      check(reg_rdata_o, exp, what);
   endtask : rd

   task automatic por_reset();
      resetn_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
   endtask : por_reset

   task automatic stop_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   // Whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         stop_test();
      end
   end

   //---------------------------------------------------------------------------
   // Tests
   //---------------------------------------------------------------------------
   initial begin
      por_reset();
      for (int p = 0; p < PRB_NPORT; p++) begin
         rd(5'(PRB_OFF_ANSEL_BASE + p), ansel_rst[p], "ansel reset");
         check(rdata_s, ansel_rst[p] & PRB_SMALL_AVAIL[p], "small ansel reset");
         rd(5'(PRB_OFF_DIR_BASE + p), (p == 4) ? 8'h87 : 8'hFF, "dir reset");
         check(rdata_s, (p == 4) ? 8'h80 : PRB_SMALL_AVAIL[p], "small dir reset");
         rd(5'(PRB_OFF_LAT_BASE + p), 8'h00, "latch reset");
         check(pad_oe_n_o[p], 8'hFF, "oe reset");
         check(pad_oe_n_s[p], 8'hFF, "small oe reset");
      end
      rd(PRB_OFF_PULLUP_B, 8'hFF, "pullup reset");
      check({7'h00, pullup_e}, 8'h01, "input pullup reset");
      $display("test reset values done");

      for (int p = 0; p < PRB_NPORT; p++) begin
         wr(5'(PRB_OFF_ANSEL_BASE + p), 8'hFF);
         rd(5'(PRB_OFF_ANSEL_BASE + p), ansel_rst[p], "ansel ones");
         wr(5'(PRB_OFF_ANSEL_BASE + p), 8'h00);
         rd(5'(PRB_OFF_ANSEL_BASE + p), 8'h00, "ansel zeros");
      end
      wr(5'h09, 8'hFF);
      rd(5'h09, 8'h07, "fifth latch mask");
      wr(5'h0E, 8'h78);
      rd(5'h0E, 8'h00, "fifth dir mask");
      check(pad_oe_n_o[4], 8'hF8, "fifth oe");
      check({7'h00, pullup_e}, 8'h00, "input pullup off");
      wr(PRB_OFF_PULLUP_B, 8'h96);
      rd(PRB_OFF_PULLUP_B, 8'h96, "pullup rw");
      check(pullup_b, 8'h96, "pullup out");
      $display("test register masks done");

      for (int p = 0; p < PRB_NPORT; p++) begin
         wr(5'(PRB_OFF_PIN_BASE + p), 8'h5A ^ 8'(p));
         rd(5'(PRB_OFF_LAT_BASE + p), (8'h5A ^ 8'(p)) & PRB_IO_MASK[p], "pin to latch");
         check(pad_out_o[p], (8'h5A ^ 8'(p)) & PRB_IO_MASK[p], "pad out");
         check(pad_out_s[p], (8'h5A ^ 8'(p)) & PRB_IO_MASK[p] & PRB_SMALL_AVAIL[p],
               "small pad out");
      end
      wr(5'h0A, 8'h0F);
      check(pad_oe_n_o[0], 8'h0F, "dir drive");
      $display("test output latches done");

      pad_in_i[0] <= 8'h3C;
      pad_in_i[1] <= 8'hC3;
      pad_in_i[4] <= 8'hFF;
      mclr_en     <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(5'h00, 8'h3C, "pin read");
      rd(5'h01, 8'hC3, "pin read b");
      wr(5'h0F, 8'h0C);
      rd(5'h00, 8'h30, "analog pin zero");
      check(pad_out_o[0], 8'h5A, "analog output kept");
      rd(5'h04, 8'h0F, "fifth pin read");
      mclr_en <= 1'b1;
      rd(5'h04, 8'h07, "master clear pin");
      pad_in_i[2] <= 8'h81;
      rd(5'h02, 8'h00, "sync not yet");
      rd(5'h02, 8'h81, "sync through");
      $display("test pin reads done");

      @(posedge clk_i);
      soft_reset_i <= 1'b1;
      @(posedge clk_i);
      soft_reset_i <= 1'b0;
      rd(5'h0A, 8'hFF, "dir soft reset");
      rd(5'h11, 8'hFC, "ansel soft reset");
      check(pullup_b, 8'hFF, "pullup soft reset");
      check({7'h00, pullup_e}, 8'h01, "input pullup soft reset");
      rd(5'h05, 8'h5A, "latch kept");
      check(pad_out_o[0], 8'h5A, "pad kept");
      wr(5'h15, 8'hFF);
      rd(5'h15, 8'h00, "unmapped");
      por_reset();
      rd(5'h05, 8'h00, "latch after power reset");
      $display("test resets done");
      stop_test();
   end
endmodule : prb_port_bank_tb
